// ---- dv/fault_logic_chk.sv ----
`timescale 1ns/1ps
module fault_logic_chk (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic drive_cmd_one,
  input wire logic drive_cmd_two,
  input wire logic drive_cmd_three,
  input wire logic drive_cmd_four,
  input wire logic drive_enable,
  input wire logic fault_resp_sel,
  input wire logic side_one_high_short_cmp,
  input wire logic side_two_high_short_cmp,
  input wire logic side_one_low_short_cmp,
  input wire logic side_two_low_short_cmp,
  input wire logic temp_hot_a,
  input wire logic temp_hot_b,
  input wire logic temp_cool_a,
  input wire logic temp_cool_b,
  input wire logic low_voltage,
  input wire logic high_gate_out_one,
  input wire logic high_gate_out_two,
  input wire logic low_gate_out_one,
  input wire logic low_gate_out_two,
  input wire logic fault_code_bit_a,
  input wire logic fault_code_bit_b
);
  wire [3:0] g = {high_gate_out_one, high_gate_out_two, low_gate_out_one, low_gate_out_two};
  wire [1:0] fc = {fault_code_bit_b, fault_code_bit_a};  // Code as {b, a}
  wire [3:0] c = {drive_cmd_one, drive_cmd_two, drive_cmd_three, drive_cmd_four};
  // Expected decode; an inhibited pattern turns every gate off
  wire [3:0] dec = ((!c[3] && !c[1]) || (!c[2] && !c[0])) ? 4'h0 :
                   {~c[3] & c[1], ~c[2] & c[0], c[3] & ~c[1], c[2] & ~c[0]};
  wire calm = !low_voltage && !temp_hot_a && !temp_hot_b;  // No higher fault coming
  wire quiet = calm && !side_one_high_short_cmp && !side_two_high_short_cmp &&
               !side_one_low_short_cmp && !side_two_low_short_cmp;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Held short, long enough for a dropped enable to be seen
  sequence held_s; (fc == 2'b10 && !drive_enable && calm)[*5]; endsequence
  sequence resume_s; (drive_enable && quiet)[*8]; endsequence
  en_low_gates_a: assert property (!drive_enable[*6] |-> g == 4'h0)
    else $error("gate driven while disabled");
  ot_path_one_a: assert property ((temp_hot_a && !low_voltage)[*7] |-> fc == 2'b11)
    else $error("first path hot but code not over-temperature");
  ot_path_two_a: assert property ((temp_hot_b && !low_voltage)[*7] |-> fc == 2'b11)
    else $error("second path hot but code not over-temperature");
  lowv_code_a: assert property (low_voltage[*6] |-> fc == 2'b00)
    else $error("low supply not reported");
  ot_hold_a: assert property ((!temp_cool_a && !temp_cool_b && !low_voltage)[*6] ##0
    fc == 2'b11 |=> fc == 2'b11) else $error("over-temperature left without cooling");
  short_force_a: assert property ((fc == 2'b10 && !fault_resp_sel)[*6] |-> g == 4'h0)
    else $error("gate driven during short with select low");
  short_decode_a: assert property ((fc == 2'b10 && fault_resp_sel && drive_enable &&
    $stable(c))[*6] |-> g == dec) else $error("decode stopped during short");
  short_latch_a: assert property ((!drive_enable && calm)[*6] ##0 fc == 2'b10
    |=> fc == 2'b10) else $error("short code dropped without enable");
  short_release_a: assert property (held_s ##1 resume_s |-> fc == 2'b01)
    else $error("short not released by enable");
endmodule

// ---- dv/host_pins.sv ----
`timescale 1ns/1ps
module host_pins (
  input  wire logic       ref_clk,
  input  wire logic [3:0] cmd,
  input  wire logic       en,
  input  wire logic       sel,
  input  wire logic       restart,
  output logic            drive_cmd_one,
  output logic            drive_cmd_two,
  output logic            drive_cmd_three,
  output logic            drive_cmd_four,
  output logic            drive_enable,
  output logic            fault_resp_sel
);
  logic [2:0] low_q = 3'h0;  // Cycles left with enable held low
  // Quiet pins at power up
  initial begin
    {drive_cmd_one, drive_cmd_two, drive_cmd_three, drive_cmd_four} = 4'h0;
    drive_enable = 1'b0;
    fault_resp_sel = 1'b0;
  end
  // Pins move just after an edge only
  always @(posedge ref_clk) begin
    {drive_cmd_one, drive_cmd_two, drive_cmd_three, drive_cmd_four} <= cmd;
    fault_resp_sel <= sel;
    // Low long enough to pass the input filter, then high
    if (restart) begin
      low_q <= 3'h5;
    end else if (low_q != 3'h0) begin
      low_q <= low_q - 3'h1;
    end
    drive_enable <= en && !restart && (low_q == 3'h0);
  end
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic        ref_clk = 1'b0;  // Core clock
  logic        rstn    = 1'b0;  // Reset, active low
  logic [3:0]  cmd     = 4'h0;  // Host nibble {one, two, three, four}
  logic        en      = 1'b0;  // Host enable request
  logic        sel     = 1'b0;  // Host select request
  logic        restart = 1'b0;  // Host restart request
  logic [3:0]  cmp     = 4'h0;  // {two low, one low, two high, one high}
  logic [1:0]  hot     = 2'h0;  // Hot per sensor path
  logic [1:0]  cool    = 2'h0;  // Cool per sensor path
  logic        lowv    = 1'b0;  // Supply low
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire         c1, c2, c3, c4, den, dsel, irq, awready, wready, bvalid, arready, rvalid;
  wire  [3:0]  g;      // {ho1, ho2, lo1, lo2}
  wire  [1:0]  fc;     // {bit b, bit a}
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  logic [31:0] d;
  logic [1:0]  rs;
  int          failures = 0, checks = 0, r;
  // Free-running clock
  always #5 ref_clk = ~ref_clk;
  host_pins host_pins_i (.ref_clk(ref_clk), .cmd(cmd), .en(en), .sel(sel), .restart(restart),
    .drive_cmd_one(c1), .drive_cmd_two(c2), .drive_cmd_three(c3), .drive_cmd_four(c4),
    .drive_enable(den), .fault_resp_sel(dsel));
  motor_predriver_fault_logic motor_predriver_fault_logic_i (.ref_clk(ref_clk), .rstn(rstn),
    .drive_cmd_one(c1), .drive_cmd_two(c2), .drive_cmd_three(c3), .drive_cmd_four(c4),
    .drive_enable(den), .fault_resp_sel(dsel),
    .side_one_high_short_cmp(cmp[0]), .side_two_high_short_cmp(cmp[1]),
    .side_one_low_short_cmp(cmp[2]), .side_two_low_short_cmp(cmp[3]),
    .temp_hot_a(hot[0]), .temp_cool_a(cool[0]), .temp_hot_b(hot[1]), .temp_cool_b(cool[1]),
    .low_voltage(lowv), .high_gate_out_one(g[3]), .high_gate_out_two(g[2]),
    .low_gate_out_one(g[1]), .low_gate_out_two(g[0]), .fault_code_bit_a(fc[0]),
    .fault_code_bit_b(fc[1]), .irq(irq), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // Expected gates {ho1, ho2, lo1, lo2} for a nibble {one, two, three, four}
  function automatic [3:0] dec(input [3:0] c, input e);
    dec = (!e || (!c[3] && !c[1]) || (!c[2] && !c[0])) ? 4'h0 :
          {~c[3] & c[1], ~c[2] & c[0], c[3] & ~c[1], c[2] & ~c[0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input string nm, input [31:0] e, input [31:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One bus transfer; the first edge keeps a released strobe from rising in the same step
  task automatic bus(input bit w, input [7:0] a, input [31:0] dv, output [31:0] q,
                     output [1:0] rsp);
    int  n;
    bit  done;
    n = 0;
    done = 0;
    @(posedge ref_clk);
    if (w) begin
      awaddr <= a;
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!done && n < 40) begin
      @(posedge ref_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      q = rdata;
      rsp = w ? bresp : rresp;
      done = w ? (bvalid && bready) : (rvalid && rready);
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (!done) begin
      failures++;
      wrap_up();
    end
  endtask
  initial begin
    r = $urandom(45);
    cyc(2);
    rstn <= 1'b1;
    chk("code", 32'h1, fc);
    chk("gates", 32'h0, g);
    chk("irq", 32'h0, irq);
    bus(0, 8'h00, 0, d, rs);
    chk("filter reset", 32'h00C8, d);
    bus(0, 8'h0C, 0, d, rs);
    chk("mask reset", 32'h0, d);
    bus(0, 8'h10, 0, d, rs);
    chk("hole read", 32'h2, rs);
    bus(1, 8'h10, 32'h5, d, rs);
    chk("hole write", 32'h2, rs);
    bus(1, 8'h00, 32'h14, d, rs);
    bus(1, 8'h0C, 32'hF, d, rs);
    $display("reset and bus test done");
    // Random commands, enable included
    sel <= 1'b1;
    repeat (16) begin
      cmd <= 4'($urandom);
      en <= 1'($urandom);
      cyc(8);
      chk("decode", dec(cmd, en), g);
    end
    cmd <= 4'h0;
    en <= 1'b1;
    // Each path alone; second pass masked
    for (int p = 0; p < 2; p++) begin
      if (p == 1) bus(1, 8'h0C, 0, d, rs);
      hot[p] <= 1'b1;
      cyc(8);
      hot[p] <= 1'b0;
      cyc(6);
      chk("ot set", 32'h3, fc);
      chk("irq", p == 0, irq);
      cyc(20);
      chk("ot kept", 32'h3, fc);
      cool[p] <= 1'b1;
      cyc(4);
      cool[p] <= 1'b0;
      cyc(6);
      chk("ot gone", 32'h1, fc);
      bus(0, 8'h08, 0, d, rs);
      chk("events", 32'h6, d);
      bus(0, 8'h08, 0, d, rs);
      chk("events cleared", 32'h0, d);
      chk("irq", 32'h0, irq);
    end
    bus(1, 8'h0C, 32'hF, d, rs);
    $display("temperature test done");
    // One comparator at a time; the first with enable low
    for (int i = 0; i < 4; i++) begin
      sel <= 1'b0;
      en <= (i != 0);
      cyc(30);
      cmp[i] <= 1'b1;
      cyc(4);
      cmp[i] <= 1'b0;
      cyc(6);
      chk("short", 32'h2, fc);
      cmd <= 4'h6;
      cyc(8);
      chk("forced", 32'h0, g);
      sel <= 1'b1;
      cyc(8);
      chk("decode in short", dec(4'h6, i != 0), g);
      chk("held", 32'h2, fc);
      en <= 1'b1;
      restart <= 1'b1;
      cyc(1);
      restart <= 1'b0;
      cyc(14);
      chk("released", 32'h1, fc);
      cmd <= 4'h0;
    end
    // Commands high mask every comparator
    cmd <= 4'hF;
    cmp <= 4'hF;
    cyc(6);
    cmp <= 4'h0;
    cyc(8);
    chk("no short", 32'h1, fc);
    // Hit inside the turn-on filter is ignored; after it, it counts
    cmd <= 4'h0;
    cyc(30);
    cmd <= 4'h6;
    cyc(6);
    cmp[1] <= 1'b1;
    cyc(3);
    cmp[1] <= 1'b0;
    cyc(10);
    chk("filtered", 32'h1, fc);
    cyc(30);
    cmp[1] <= 1'b1;
    cyc(3);
    cmp[1] <= 1'b0;
    cyc(8);
    chk("after filter", 32'h2, fc);
    restart <= 1'b1;
    cyc(1);
    restart <= 1'b0;
    cyc(14);
    bus(0, 8'h08, 0, d, rs);
    chk("short event", 32'h1, d);
    $display("short test done");
    // Low supply outranks heat
    lowv <= 1'b1;
    hot[0] <= 1'b1;
    cyc(8);
    chk("low supply", 32'h0, fc);
    lowv <= 1'b0;
    cyc(8);
    chk("heat under", 32'h3, fc);
    hot[0] <= 1'b0;
    cool[0] <= 1'b1;
    cyc(4);
    cool[0] <= 1'b0;
    cyc(6);
    chk("normal", 32'h1, fc);
    bus(0, 8'h08, 0, d, rs);
    chk("events", 32'hE, d);
    $display("priority test done");
    wrap_up();
  end
endmodule
bind motor_predriver_fault_logic fault_logic_chk chk_i (.*);

// ---- rtl/fault_logic_regs.vh ----
`ifndef FAULT_LOGIC_REGS_VH
`define FAULT_LOGIC_REGS_VH

// Clock and filter timing
`define CLK_PERIOD_NS    10
`define FILTER_TIME_NS   2000
`define FILTER_CYC       (`FILTER_TIME_NS / `CLK_PERIOD_NS)

// Register byte offsets
`define OFS_CTRL         8'h00
`define OFS_STATUS       8'h04
`define OFS_IRQ_STAT     8'h08
`define OFS_IRQ_MASK     8'h0C

// Reset values
`define RST_FILTER       16'h00C8
`define RST_IRQ_MASK     4'h0

// Interrupt status bit positions
`define IRQ_SHORT        0
`define IRQ_OT_SET       1
`define IRQ_OT_CLR       2
`define IRQ_LOWV         3

// Status register bit positions
`define ST_CODE_A        0
`define ST_CODE_B        1
`define ST_OT            2
`define ST_SHORT         3
`define ST_LOWV          4
`define ST_OT_PATH       5
`define ST_HITS          7
`define ST_GATES         11
`define ST_BLANK         15

// Fault code values {bit_b, bit_a}
`define CODE_NORMAL      2'b01
`define CODE_LOWV        2'b00
`define CODE_SHORT       2'b10
`define CODE_OT          2'b11

// Bus responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

// Count of synchronised pin inputs
`define NUM_PINS         15

`endif

// ---- rtl/motor_predriver_fault_logic.v ----
// Functional notes
// - Over-temperature drives both code bits high.
// - Release only below lower threshold; code normal.
// - Two redundant temperature paths; either raises fault.
// - Short latches code a low, b high.
// - Enable releases short latch; code normal.
// - Short with select low forces gates low.
// - Short with select high keeps normal decoding.
// - Ignore short comparators during post-turn-on filter.
// - Short detection runs when disabled or inhibited.
// - High-side short: sense high, command off.
// - Low-side short: sense low, command off.
// - Priority low voltage, over-temperature, short.
// - Enable low holds all gates low.
`timescale 1ns/1ps
`include "fault_logic_regs.vh"

module motor_predriver_fault_logic (
  input  wire        ref_clk,
  input  wire        rstn,
  // Host drive pins
  input  wire        drive_cmd_one,
  input  wire        drive_cmd_two,
  input  wire        drive_cmd_three,
  input  wire        drive_cmd_four,
  input  wire        drive_enable,
  input  wire        fault_resp_sel,
  // Analog comparator results
  input  wire        side_one_high_short_cmp,
  input  wire        side_two_high_short_cmp,
  input  wire        side_one_low_short_cmp,
  input  wire        side_two_low_short_cmp,
  // Redundant temperature sensors
  input  wire        temp_hot_a,
  input  wire        temp_cool_a,
  input  wire        temp_hot_b,
  input  wire        temp_cool_b,
  // Supply monitor
  input  wire        low_voltage,
  // Gate drive and fault code
  output reg         high_gate_out_one,
  output reg         high_gate_out_two,
  output reg         low_gate_out_one,
  output reg         low_gate_out_two,
  output reg         fault_code_bit_a,
  output reg         fault_code_bit_b,
  output reg         irq,
  // AXI4-Lite slave
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready
);

  // Pin vector, one entry per asynchronous input
  wire [`NUM_PINS-1:0] pin_raw;
  reg  [`NUM_PINS-1:0] s1_q;      // First stage, read only by s2
  reg  [`NUM_PINS-1:0] s2_q;      // Second stage
  reg  [`NUM_PINS-1:0] s3_q;      // Third stage
  reg  [`NUM_PINS-1:0] pin_q;     // Accepted value

  assign pin_raw = {low_voltage, temp_cool_b, temp_hot_b, temp_cool_a,
                    temp_hot_a, side_two_low_short_cmp, side_one_low_short_cmp,
                    side_two_high_short_cmp, side_one_high_short_cmp,
                    fault_resp_sel, drive_enable, drive_cmd_four,
                    drive_cmd_three, drive_cmd_two, drive_cmd_one};

  // Three-stage sync; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_PINS; gi = gi + 1) begin : g_sync
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          s1_q[gi]  <= 1'b0;
          s2_q[gi]  <= 1'b0;
          s3_q[gi]  <= 1'b0;
          pin_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          // Glitch of one cycle is dropped here
          if (s2_q[gi] == s3_q[gi]) begin
            pin_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // Clean names for the synchronised pins
  wire cmd1   = pin_q[0];
  wire cmd2   = pin_q[1];
  wire cmd3   = pin_q[2];
  wire cmd4   = pin_q[3];
  wire en     = pin_q[4];
  wire sel    = pin_q[5];
  wire c_h1   = pin_q[6];
  wire c_h2   = pin_q[7];
  wire c_l1   = pin_q[8];
  wire c_l2   = pin_q[9];
  wire hot_a  = pin_q[10];
  wire cool_a = pin_q[11];
  wire hot_b  = pin_q[12];
  wire cool_b = pin_q[13];
  wire lowv   = pin_q[14];

  // Fault and control state
  reg         ot_a_q;       // Temperature path A latched hot
  reg         ot_b_q;       // Temperature path B latched hot
  reg         short_q;      // Short fault latch
  reg         en_prev_q;    // Enable of last cycle, for edge detect
  reg         lowv_prev_q;  // Low voltage of last cycle
  reg  [15:0] blank_q;      // Filter countdown after turn-on
  reg  [15:0] filter_q;     // Software filter length in cycles
  reg  [3:0]  irq_stat_q;   // Sticky events
  reg  [3:0]  irq_mask_q;   // Event enables
  reg  [3:0]  hits_q;       // Last raw short hits, for status

  wire ot_any = ot_a_q | ot_b_q;

  // Short hits straight from comparators and raw commands
  wire [3:0] hit;
  assign hit[0] = c_h1 & ~cmd3;
  assign hit[1] = c_h2 & ~cmd4;
  assign hit[2] = c_l1 & ~cmd1;
  assign hit[3] = c_l2 & ~cmd2;

  // Filter gates off hits right after a driver turns on
  wire blanking = (blank_q != 16'h0000);
  wire short_hit = (|hit) & ~blanking;
  // Release on rising enable; a fresh hit still wins
  wire en_rise = en & ~en_prev_q;
  // Leaving low voltage with select low falls into a held short
  wire lowv_exit = lowv_prev_q & ~lowv & ~sel;

  // Truth-table decode of the drive commands
  wire inhibit = (~cmd1 & ~cmd3) | (~cmd2 & ~cmd4);
  wire [3:0] dec;
  assign dec[0] = ~cmd1 & cmd3 & ~inhibit;   // High side one
  assign dec[1] = ~cmd2 & cmd4 & ~inhibit;   // High side two
  assign dec[2] = cmd1 & ~cmd3 & ~inhibit;   // Low side one
  assign dec[3] = cmd2 & ~cmd4 & ~inhibit;   // Low side two

  // Gate outputs after enable and fault gating
  reg  [3:0] gate_d;
  always @* begin
    if (!en) begin
      gate_d = 4'h0;
    end else if (lowv && !sel) begin
      gate_d = 4'h0;
    end else if (short_q && !sel) begin
      gate_d = 4'h0;
    end else begin
      gate_d = dec;
    end
  end

  wire [3:0] gate_q = {low_gate_out_two, low_gate_out_one,
                       high_gate_out_two, high_gate_out_one};
  wire turn_on = |(gate_d & ~gate_q);

  // Fault code with fixed priority
  reg  [1:0] code_d;
  always @* begin
    if (lowv) begin
      code_d = `CODE_LOWV;
    end else if (ot_any) begin
      code_d = `CODE_OT;
    end else if (short_q) begin
      code_d = `CODE_SHORT;
    end else begin
      code_d = `CODE_NORMAL;
    end
  end

  // Core fault state, gate and code registers
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ot_a_q            <= 1'b0;
      ot_b_q            <= 1'b0;
      short_q           <= 1'b0;
      en_prev_q         <= 1'b0;
      lowv_prev_q       <= 1'b0;
      blank_q           <= 16'h0000;
      hits_q            <= 4'h0;
      high_gate_out_one <= 1'b0;
      high_gate_out_two <= 1'b0;
      low_gate_out_one  <= 1'b0;
      low_gate_out_two  <= 1'b0;
      fault_code_bit_a  <= 1'b1;
      fault_code_bit_b  <= 1'b0;
    end else begin
      // Each path holds hot until its own cool flag
      if (hot_a) begin
        ot_a_q <= 1'b1;
      end else if (cool_a) begin
        ot_a_q <= 1'b0;
      end
      if (hot_b) begin
        ot_b_q <= 1'b1;
      end else if (cool_b) begin
        ot_b_q <= 1'b0;
      end
      // Detection ignores enable and inhibit on purpose
      if (short_hit || lowv_exit) begin
        short_q <= 1'b1;
      end else if (en_rise) begin
        short_q <= 1'b0;
      end
      en_prev_q   <= en;
      lowv_prev_q <= lowv;
      hits_q      <= hit;
      // Reload filter on any gate turning on
      if (turn_on) begin
        blank_q <= filter_q;
      end else if (blanking) begin
        blank_q <= blank_q - 16'h0001;
      end
      high_gate_out_one <= gate_d[0];
      high_gate_out_two <= gate_d[1];
      low_gate_out_one  <= gate_d[2];
      low_gate_out_two  <= gate_d[3];
      fault_code_bit_a  <= code_d[0];
      fault_code_bit_b  <= code_d[1];
    end
  end

  // Events for the interrupt status
  wire [3:0] ev;
  assign ev[`IRQ_SHORT]  = (short_hit | lowv_exit) & ~short_q;
  assign ev[`IRQ_OT_SET] = ~ot_any & (hot_a | hot_b);
  assign ev[`IRQ_OT_CLR] = ot_any & ~((ot_a_q & ~cool_a) | hot_a)
                                  & ~((ot_b_q & ~cool_b) | hot_b);
  assign ev[`IRQ_LOWV]   = lowv & ~lowv_prev_q;

  // Status word seen by software
  wire [31:0] status_w;
  assign status_w = {16'h0000, blanking, gate_q, hits_q, ot_b_q, ot_a_q,
                     lowv, short_q, ot_any, fault_code_bit_b,
                     fault_code_bit_a};

  // Write channel state
  reg        aw_got_q;    // Address held
  reg        w_got_q;     // Data held
  reg  [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg  [3:0] wstrb_q;

  wire aw_hs  = awvalid & awready;
  wire w_hs   = wvalid & wready;
  wire do_wr  = aw_got_q & w_got_q & ~bvalid;
  wire ar_hs  = arvalid & arready;
  wire rd_irq = ar_hs & (araddr[7:2] == `OFS_IRQ_STAT >> 2);

  // Write-data merge under strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (st[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  wire [31:0] ctrl_new = merge({16'h0000, filter_q}, wdata_q, wstrb_q);
  wire [31:0] mask_new = merge({28'h0, irq_mask_q}, wdata_q, wstrb_q);
  wire wr_ctrl = do_wr & (awaddr_q[7:2] == `OFS_CTRL >> 2);
  wire wr_mask = do_wr & (awaddr_q[7:2] == `OFS_IRQ_MASK >> 2);
  wire wr_ok   = wr_ctrl | wr_mask |
                 (awaddr_q[7:2] == `OFS_STATUS >> 2) |
                 (awaddr_q[7:2] == `OFS_IRQ_STAT >> 2);

  // Write path: take address and data in any order, then answer
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      aw_got_q   <= 1'b0;
      w_got_q    <= 1'b0;
      awaddr_q   <= 8'h00;
      wdata_q    <= 32'h00000000;
      wstrb_q    <= 4'h0;
      bvalid     <= 1'b0;
      bresp      <= `RESP_OKAY;
      filter_q   <= `RST_FILTER;
      irq_mask_q <= `RST_IRQ_MASK;
    end else begin
      if (aw_hs) begin
        awaddr_q <= awaddr;
        aw_got_q <= 1'b1;
        awready  <= 1'b0;
      end
      if (w_hs) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        w_got_q <= 1'b1;
        wready  <= 1'b0;
      end
      // Read-only registers accept writes silently
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_ctrl) begin
          filter_q <= ctrl_new[15:0];
        end
        if (wr_mask) begin
          irq_mask_q <= mask_new[3:0];
        end
      end
      // Reopen both channels once the answer is taken
      if (bvalid && bready) begin
        bvalid   <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        awready  <= 1'b1;
        wready   <= 1'b1;
      end
    end
  end

  // Read mux for the address on araddr
  reg [31:0] rmux;
  reg        rok;
  always @* begin
    rok = 1'b1;
    case (araddr[7:2])
      `OFS_CTRL >> 2:     rmux = {16'h0000, filter_q};
      `OFS_STATUS >> 2:   rmux = status_w;
      `OFS_IRQ_STAT >> 2: rmux = {28'h0, irq_stat_q};
      `OFS_IRQ_MASK >> 2: rmux = {28'h0, irq_mask_q};
      default: begin
        rmux = 32'h00000000;
        rok  = 1'b0;
      end
    endcase
  end

  // Read path: one outstanding read, answered next cycle
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `RESP_OKAY;
    end else begin
      if (ar_hs) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rmux;
        rresp   <= rok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Sticky events; read clears what it returned, new events win
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_q <= 4'h0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(rd_irq ? irq_stat_q : 4'h0)) | ev;
      irq        <= |(((irq_stat_q & ~(rd_irq ? irq_stat_q : 4'h0)) | ev)
                      & irq_mask_q);
    end
  end

endmodule
